//--- rtl/iopcn_top.sv
`timescale 1ns/1ps
module iopcn_top (
	input wire logic core_clk, // System clock, 50 MHz.
	input wire logic rst, // Synchronous reset, active high.
	input wire logic [iopcn_pkg::ADDR_W-1:0] reg_addr, // Register byte address.
	input wire logic [iopcn_pkg::DATA_W-1:0] reg_wdata, // Register write data.
	input wire logic reg_wr, // Write strobe.
	input wire logic reg_rd, // Read strobe.
	output logic [iopcn_pkg::DATA_W-1:0] reg_rdata, // Read data, cycle after strobe.
	input wire logic [iopcn_pkg::PORT_W-1:0] pin_in, // Pad input levels.
	output logic [iopcn_pkg::PORT_W-1:0] pin_out, // Pad output levels.
	output logic [iopcn_pkg::PORT_W-1:0] pin_oe_n, // Pad drive enables, low drives.
	output logic [iopcn_pkg::AN_W-1:0] analog_channel_pins, // High where a pin is analog.
	output logic [iopcn_pkg::AN_W-1:0] adc_route_en, // High where converter may sample.
	input wire logic [iopcn_pkg::CN_W-1:0] change_notify_inputs, // Change inputs.
	output logic [iopcn_pkg::CN_W-1:0] pullup_en, // Weak pull-up enables.
	output logic irq, // Level interrupt output.
	output logic cn_wake_req // Unclocked wake request for sleep.
);

	typedef logic [iopcn_pkg::DATA_W-1:0] iopcn_w_t;

	// Analog when the bit is clear in either converter's register.
	function automatic iopcn_w_t iopcn_analog(input iopcn_w_t cfg_a, input iopcn_w_t cfg_b);
		iopcn_analog = ~cfg_a | ~cfg_b;
	endfunction : iopcn_analog

	function automatic logic iopcn_hit(input iopcn_pkg::iopcn_addr_t a,
		input iopcn_pkg::iopcn_addr_t ofs);
		iopcn_hit = (a == ofs);
	endfunction : iopcn_hit

	logic [iopcn_pkg::PORT_W-1:0] pin_direction_bits_q;
	logic [iopcn_pkg::PORT_W-1:0] pin_direction_bits_d;
	logic [iopcn_pkg::PORT_W-1:0] output_latch_bits_q;
	logic [iopcn_pkg::PORT_W-1:0] output_latch_bits_d;
	logic [iopcn_pkg::PORT_W-1:0] open_drain_select_q;
	logic [iopcn_pkg::PORT_W-1:0] open_drain_select_d;
	iopcn_w_t analog_select_low1_q;
	iopcn_w_t analog_select_low1_d;
	iopcn_w_t analog_select_high1_q;
	iopcn_w_t analog_select_high1_d;
	iopcn_w_t analog_select_low2_q;
	iopcn_w_t analog_select_low2_d;
	iopcn_w_t analog_select_high2_q;
	iopcn_w_t analog_select_high2_d;
	iopcn_w_t change_irq_enable_reg1_q;
	iopcn_w_t change_irq_enable_reg1_d;
	logic [iopcn_pkg::CN_HI_W-1:0] change_irq_enable_reg2_q;
	logic [iopcn_pkg::CN_HI_W-1:0] change_irq_enable_reg2_d;
	iopcn_w_t pullup_enable_reg1_q;
	iopcn_w_t pullup_enable_reg1_d;
	logic [iopcn_pkg::CN_HI_W-1:0] pullup_enable_reg2_q;
	logic [iopcn_pkg::CN_HI_W-1:0] pullup_enable_reg2_d;
	logic [iopcn_pkg::IRQ_W-1:0] irq_stat_q;
	logic [iopcn_pkg::IRQ_W-1:0] irq_stat_d;
	logic [iopcn_pkg::IRQ_W-1:0] irq_mask_q;
	logic [iopcn_pkg::IRQ_W-1:0] irq_mask_d;
	iopcn_w_t rdata_q;
	iopcn_w_t rdata_d;

	logic [iopcn_pkg::PORT_W-1:0] pin_sync;
	logic [iopcn_pkg::CN_W-1:0] cn_sync;
	logic [iopcn_pkg::CN_W-1:0] cn_enable;
	logic [iopcn_pkg::AN_W-1:0] analog_map;
	logic [iopcn_pkg::PORT_W-1:0] pin_level_view;
	logic change_pulse;
	logic [iopcn_pkg::IRQ_W-1:0] irq_events;

	iopcn_sync #(
		.WIDTH(iopcn_pkg::PORT_W)
	) u_pin_sync (
		.core_clk(core_clk),
		.rst(rst),
		.async_in(pin_in),
		.sync_out(pin_sync)
	);

	iopcn_sync #(
		.WIDTH(iopcn_pkg::CN_W)
	) u_cn_sync (
		.core_clk(core_clk),
		.rst(rst),
		.async_in(change_notify_inputs),
		.sync_out(cn_sync)
	);

	iopcn_cndet u_cndet (
		.core_clk(core_clk),
		.rst(rst),
		.cn_sync(cn_sync),
		.cn_raw(change_notify_inputs),
		.cn_en(cn_enable),
		.change_pulse(change_pulse),
		.wake_req(cn_wake_req)
	);

	// Analog selection: either converter's cleared bit makes the pin analog.
	always_comb
	begin
		analog_map = {iopcn_analog(analog_select_high1_q, analog_select_high2_q),
			iopcn_analog(analog_select_low1_q, analog_select_low2_q)};
	end

	// Digital inputs never reach the converter; analog pins with a cleared
	// direction bit still drive, so the converter sees the driven level.
	assign analog_channel_pins = analog_map;
	assign adc_route_en = analog_map;

	// Pin drivers.
	always_comb
	begin
		for (int i = 0; i < iopcn_pkg::PORT_W; i++)
		begin
			if (open_drain_select_q[i])
			begin
				pin_out[i] = 1'b0;
				pin_oe_n[i] = pin_direction_bits_q[i] | output_latch_bits_q[i];
			end
			else
			begin
				pin_out[i] = output_latch_bits_q[i];
				pin_oe_n[i] = pin_direction_bits_q[i];
			end
		end
	end

	// Analog pins read as low whatever the pad shows.
	assign pin_level_view = pin_sync & ~analog_map[iopcn_pkg::PORT_W-1:0];

	assign cn_enable = {change_irq_enable_reg2_q, change_irq_enable_reg1_q};
	assign pullup_en = {pullup_enable_reg2_q, pullup_enable_reg1_q};

	always_comb
	begin
		irq_events = '0;
		irq_events[iopcn_pkg::IRQ_BIT_CN] = change_pulse;
	end

	// Register writes.
	always_comb
	begin
		pin_direction_bits_d = pin_direction_bits_q;
		output_latch_bits_d = output_latch_bits_q;
		open_drain_select_d = open_drain_select_q;
		analog_select_low1_d = analog_select_low1_q;
		analog_select_high1_d = analog_select_high1_q;
		analog_select_low2_d = analog_select_low2_q;
		analog_select_high2_d = analog_select_high2_q;
		change_irq_enable_reg1_d = change_irq_enable_reg1_q;
		change_irq_enable_reg2_d = change_irq_enable_reg2_q;
		pullup_enable_reg1_d = pullup_enable_reg1_q;
		pullup_enable_reg2_d = pullup_enable_reg2_q;
		irq_mask_d = irq_mask_q;
		if (reg_wr)
		begin
			unique case (1'b1)
				iopcn_hit(reg_addr, iopcn_pkg::OFS_DIR):
					pin_direction_bits_d = reg_wdata;
				iopcn_hit(reg_addr, iopcn_pkg::OFS_LATCH):
					output_latch_bits_d = reg_wdata;
				iopcn_hit(reg_addr, iopcn_pkg::OFS_ODSEL):
					open_drain_select_d = reg_wdata;
				iopcn_hit(reg_addr, iopcn_pkg::OFS_ANA1_LO):
					analog_select_low1_d = reg_wdata;
				iopcn_hit(reg_addr, iopcn_pkg::OFS_ANA1_HI):
					analog_select_high1_d = reg_wdata;
				iopcn_hit(reg_addr, iopcn_pkg::OFS_ANA2_LO):
					analog_select_low2_d = reg_wdata;
				iopcn_hit(reg_addr, iopcn_pkg::OFS_ANA2_HI):
					analog_select_high2_d = reg_wdata;
				iopcn_hit(reg_addr, iopcn_pkg::OFS_CHANGE_IRQ_ENABLE_REG1):
					change_irq_enable_reg1_d = reg_wdata;
				iopcn_hit(reg_addr, iopcn_pkg::OFS_CHANGE_IRQ_ENABLE_REG2):
					change_irq_enable_reg2_d = reg_wdata[iopcn_pkg::CN_HI_W-1:0];
				iopcn_hit(reg_addr, iopcn_pkg::OFS_PULLUP_ENABLE_REG1):
					pullup_enable_reg1_d = reg_wdata;
				iopcn_hit(reg_addr, iopcn_pkg::OFS_PULLUP_ENABLE_REG2):
					pullup_enable_reg2_d = reg_wdata[iopcn_pkg::CN_HI_W-1:0];
				iopcn_hit(reg_addr, iopcn_pkg::OFS_IRQ_MASK):
					irq_mask_d = reg_wdata[iopcn_pkg::IRQ_W-1:0];
				default:
				begin
				end
			endcase
		end
	end

	// Sticky status: a read clears it, but a new event in that cycle wins.
	always_comb
	begin
		irq_stat_d = irq_stat_q;
		if (reg_rd && iopcn_hit(reg_addr, iopcn_pkg::OFS_IRQ_STAT))
		begin
			irq_stat_d = '0;
		end
		irq_stat_d = irq_stat_d | irq_events;
	end

	// Read mux; unmapped addresses read as zero.
	always_comb
	begin
		rdata_d = '0;
		if (reg_rd)
		begin
			unique case (1'b1)
				iopcn_hit(reg_addr, iopcn_pkg::OFS_DIR):
					rdata_d = pin_direction_bits_q;
				iopcn_hit(reg_addr, iopcn_pkg::OFS_PINS):
					rdata_d = pin_level_view;
				iopcn_hit(reg_addr, iopcn_pkg::OFS_LATCH):
					rdata_d = output_latch_bits_q;
				iopcn_hit(reg_addr, iopcn_pkg::OFS_ODSEL):
					rdata_d = open_drain_select_q;
				iopcn_hit(reg_addr, iopcn_pkg::OFS_ANA1_LO):
					rdata_d = analog_select_low1_q;
				iopcn_hit(reg_addr, iopcn_pkg::OFS_ANA1_HI):
					rdata_d = analog_select_high1_q;
				iopcn_hit(reg_addr, iopcn_pkg::OFS_ANA2_LO):
					rdata_d = analog_select_low2_q;
				iopcn_hit(reg_addr, iopcn_pkg::OFS_ANA2_HI):
					rdata_d = analog_select_high2_q;
				iopcn_hit(reg_addr, iopcn_pkg::OFS_CHANGE_IRQ_ENABLE_REG1):
					rdata_d = change_irq_enable_reg1_q;
				iopcn_hit(reg_addr, iopcn_pkg::OFS_CHANGE_IRQ_ENABLE_REG2):
					rdata_d[iopcn_pkg::CN_HI_W-1:0] = change_irq_enable_reg2_q;
				iopcn_hit(reg_addr, iopcn_pkg::OFS_PULLUP_ENABLE_REG1):
					rdata_d = pullup_enable_reg1_q;
				iopcn_hit(reg_addr, iopcn_pkg::OFS_PULLUP_ENABLE_REG2):
					rdata_d[iopcn_pkg::CN_HI_W-1:0] = pullup_enable_reg2_q;
				iopcn_hit(reg_addr, iopcn_pkg::OFS_IRQ_STAT):
					rdata_d[iopcn_pkg::IRQ_W-1:0] = irq_stat_q;
				iopcn_hit(reg_addr, iopcn_pkg::OFS_IRQ_MASK):
					rdata_d[iopcn_pkg::IRQ_W-1:0] = irq_mask_q;
				default:
				begin
				end
			endcase
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			pin_direction_bits_q <= iopcn_pkg::RST_DIR;
			output_latch_bits_q <= iopcn_pkg::RST_ZERO;
			open_drain_select_q <= iopcn_pkg::RST_ZERO;
			analog_select_low1_q <= iopcn_pkg::RST_ANA;
			analog_select_high1_q <= iopcn_pkg::RST_ANA;
			analog_select_low2_q <= iopcn_pkg::RST_ANA;
			analog_select_high2_q <= iopcn_pkg::RST_ANA;
			change_irq_enable_reg1_q <= iopcn_pkg::RST_ZERO;
			change_irq_enable_reg2_q <= '0;
			pullup_enable_reg1_q <= iopcn_pkg::RST_ZERO;
			pullup_enable_reg2_q <= '0;
			irq_stat_q <= '0;
			irq_mask_q <= '0;
			rdata_q <= iopcn_pkg::RST_ZERO;
		end
		else
		begin
			pin_direction_bits_q <= pin_direction_bits_d;
			output_latch_bits_q <= output_latch_bits_d;
			open_drain_select_q <= open_drain_select_d;
			analog_select_low1_q <= analog_select_low1_d;
			analog_select_high1_q <= analog_select_high1_d;
			analog_select_low2_q <= analog_select_low2_d;
			analog_select_high2_q <= analog_select_high2_d;
			change_irq_enable_reg1_q <= change_irq_enable_reg1_d;
			change_irq_enable_reg2_q <= change_irq_enable_reg2_d;
			pullup_enable_reg1_q <= pullup_enable_reg1_d;
			pullup_enable_reg2_q <= pullup_enable_reg2_d;
			irq_stat_q <= irq_stat_d;
			irq_mask_q <= irq_mask_d;
			rdata_q <= rdata_d;
		end
	end

	assign reg_rdata = rdata_q;
	assign irq = |(irq_stat_q & irq_mask_q);

endmodule : iopcn_top

//--- rtl/iopcn_pkg.sv
package iopcn_pkg;

	// Widths of the port, the converter channel map and the register bus.
	localparam int PORT_W = 16;
	localparam int AN_W = 32;
	localparam int CN_W = 24;
	localparam int CN_LO_W = 16;
	localparam int CN_HI_W = CN_W - CN_LO_W;
	localparam int DATA_W = 16;
	localparam int ADDR_W = 8;

	typedef logic [ADDR_W-1:0] iopcn_addr_t;
	typedef logic [DATA_W-1:0] iopcn_word_t;

	// Register byte offsets.
	localparam iopcn_addr_t OFS_DIR = 8'h00;
	localparam iopcn_addr_t OFS_PINS = 8'h02;
	localparam iopcn_addr_t OFS_LATCH = 8'h04;
	localparam iopcn_addr_t OFS_ODSEL = 8'h06;
	localparam iopcn_addr_t OFS_ANA1_LO = 8'h08;
	localparam iopcn_addr_t OFS_ANA1_HI = 8'h0a;
	localparam iopcn_addr_t OFS_ANA2_LO = 8'h0c;
	localparam iopcn_addr_t OFS_ANA2_HI = 8'h0e;
	localparam iopcn_addr_t OFS_CHANGE_IRQ_ENABLE_REG1 = 8'h10;
	localparam iopcn_addr_t OFS_CHANGE_IRQ_ENABLE_REG2 = 8'h12;
	localparam iopcn_addr_t OFS_PULLUP_ENABLE_REG1 = 8'h14;
	localparam iopcn_addr_t OFS_PULLUP_ENABLE_REG2 = 8'h16;
	localparam iopcn_addr_t OFS_IRQ_STAT = 8'h18;
	localparam iopcn_addr_t OFS_IRQ_MASK = 8'h1a;

	// Reset values.
	localparam iopcn_word_t RST_DIR = 16'hffff;
	localparam iopcn_word_t RST_ZERO = 16'h0000;
	localparam iopcn_word_t RST_ANA = 16'h0000;

	// Status and mask layout.
	localparam int IRQ_W = 1;
	localparam int IRQ_BIT_CN = 0;

endpackage : iopcn_pkg

//--- rtl/iopcn_sync.sv
`timescale 1ns/1ps
module iopcn_sync #(
	parameter int WIDTH = 1
) (
	input wire logic core_clk, // System clock.
	input wire logic rst, // Synchronous reset, active high.
	input wire logic [WIDTH-1:0] async_in, // Level from outside the clock domain.
	output logic [WIDTH-1:0] sync_out // Level after two flip-flops.
);

	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] meta_d;
	logic [WIDTH-1:0] sync_q;
	logic [WIDTH-1:0] sync_d;

	always_comb
	begin
		meta_d = async_in;
		sync_d = meta_q;
	end

	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			meta_q <= '0;
			sync_q <= '0;
		end
		else
		begin
			meta_q <= meta_d;
			sync_q <= sync_d;
		end
	end

	assign sync_out = sync_q;

endmodule : iopcn_sync

//--- rtl/iopcn_cndet.sv
`timescale 1ns/1ps
module iopcn_cndet (
	input wire logic core_clk, // System clock.
	input wire logic rst, // Synchronous reset, active high.
	input wire logic [iopcn_pkg::CN_W-1:0] cn_sync, // Synchronised change inputs.
	input wire logic [iopcn_pkg::CN_W-1:0] cn_raw, // Change inputs straight from pins.
	input wire logic [iopcn_pkg::CN_W-1:0] cn_en, // Per-input change enables.
	output logic change_pulse, // One-cycle pulse on an enabled mismatch.
	output logic wake_req // Unclocked request for a stopped clock.
);

	logic [iopcn_pkg::CN_W-1:0] last_q;
	logic [iopcn_pkg::CN_W-1:0] last_d;
	logic change_q;
	logic change_d;

	// Compare with the recorded level, flag a mismatch, then record anew.
	always_comb
	begin
		change_d = |(cn_en & (cn_sync ^ last_q));
		last_d = cn_sync;
	end

	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			last_q <= '0;
			change_q <= 1'b0;
		end
		else
		begin
			last_q <= last_d;
			change_q <= change_d;
		end
	end

	assign change_pulse = change_q;
	// Works with the clock stopped: raw pins against the last recorded level.
	assign wake_req = |(cn_en & (cn_raw ^ last_q));

endmodule : iopcn_cndet

//--- sim/iopcn_pads.sv
`timescale 1ns/1ps
module iopcn_pads (
	input wire logic core_clk, // Clock for the floating pattern.
	input wire logic [iopcn_pkg::PORT_W-1:0] pin_out, // Device pad levels.
	input wire logic [iopcn_pkg::PORT_W-1:0] pin_oe_n, // Device drive enables.
	input wire logic [iopcn_pkg::PORT_W-1:0] ext_val, // Outside levels.
	input wire logic [iopcn_pkg::PORT_W-1:0] ext_drv, // Outside drives.
	input wire logic [iopcn_pkg::CN_W-1:0] cn_val, // Switch levels.
	input wire logic [iopcn_pkg::CN_W-1:0] cn_drv, // Switch drives.
	input wire logic [iopcn_pkg::CN_W-1:0] pullup_en, // Weak pull-ups.
	output logic [iopcn_pkg::PORT_W-1:0] pin_in, // Pad levels seen by the device.
	output logic [iopcn_pkg::CN_W-1:0] change_notify_inputs // Change input levels.
);
	logic float_q = 1'b0;
	always @(posedge core_clk) float_q <= ~float_q;
	// Released port pads sit at the board pull-up level.
	assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & ((ext_drv & ext_val) | ~ext_drv));
	// An open change input without pull-up flips every cycle, so no value is assumed.
	assign change_notify_inputs = (cn_drv & cn_val) |
		(~cn_drv & (pullup_en | {iopcn_pkg::CN_W{float_q}}));
endmodule : iopcn_pads

//--- sim/iopcn_assertions.sv
`timescale 1ns/1ps
module iopcn_chk (
	input wire logic core_clk, // Clock.
	input wire logic rst, // Reset.
	input wire logic [iopcn_pkg::ADDR_W-1:0] reg_addr, // Address.
	input wire logic [iopcn_pkg::DATA_W-1:0] reg_wdata, // Write data.
	input wire logic reg_wr, // Write strobe.
	input wire logic reg_rd, // Read strobe.
	input wire logic [iopcn_pkg::DATA_W-1:0] reg_rdata, // Read data.
	input wire logic [iopcn_pkg::PORT_W-1:0] pin_out, // Pad levels.
	input wire logic [iopcn_pkg::PORT_W-1:0] pin_oe_n, // Pad enables.
	input wire logic [iopcn_pkg::AN_W-1:0] analog_channel_pins, // Analog map.
	input wire logic [iopcn_pkg::AN_W-1:0] adc_route_en, // Converter routing.
	input wire logic [iopcn_pkg::CN_W-1:0] pullup_en, // Pull-ups.
	input wire logic irq, // Interrupt.
	input wire logic cn_wake_req // Wake request.
);
	logic mask_q;
	logic mask_d;
	always_comb
	begin
		mask_d = mask_q;
		if (reg_wr && reg_addr == iopcn_pkg::OFS_IRQ_MASK)
			mask_d = reg_wdata[iopcn_pkg::IRQ_BIT_CN];
	end
	always_ff @(posedge core_clk)
	begin
		if (rst)
			mask_q <= 1'b0;
		else
			mask_q <= mask_d;
	end
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);
	route_follows_map_a: assert property (adc_route_en == analog_channel_pins)
		else $error("converter routing differs from analog map");
	reset_analog_a: assert property ($fell(rst) |-> analog_channel_pins == '1)
		else $error("pins not analog after reset");
	reset_inputs_a: assert property ($fell(rst) |-> pin_oe_n == '1)
		else $error("pin driven after reset");
	pins_read_a: assert property (reg_rd && reg_addr == iopcn_pkg::OFS_PINS
		|=> (reg_rdata & analog_channel_pins[15:0]) == 16'h0000)
		else $error("analog pin read nonzero");
	dir_input_a: assert property (reg_wr && reg_addr == iopcn_pkg::OFS_DIR
		|=> (~pin_oe_n & $past(reg_wdata)) == 16'h0000)
		else $error("input pin still driven");
	od_low_only_a: assert property (reg_wr && reg_addr == iopcn_pkg::OFS_ODSEL
		|=> (pin_out & $past(reg_wdata)) == 16'h0000)
		else $error("open-drain pin drives high");
	pullup_low_a: assert property (reg_wr && reg_addr == iopcn_pkg::OFS_PULLUP_ENABLE_REG1
		|=> pullup_en[15:0] == $past(reg_wdata))
		else $error("low pull-ups not taken");
	pullup_high_a: assert property (reg_wr && reg_addr == iopcn_pkg::OFS_PULLUP_ENABLE_REG2
		|=> pullup_en[23:16] == $past(reg_wdata[7:0]))
		else $error("high pull-ups not taken");
	change_irq_a: assert property (cn_wake_req && mask_q |-> ##[1:6] irq)
		else $error("enabled change gave no interrupt");
	irq_masked_a: assert property (!mask_q |-> !irq)
		else $error("interrupt while masked");
	irq_sticky_a: assert property ($fell(irq) |-> $past(rst) ||
		$past(reg_rd && reg_addr == iopcn_pkg::OFS_IRQ_STAT) ||
		$past(reg_wr && reg_addr == iopcn_pkg::OFS_IRQ_MASK))
		else $error("interrupt dropped without clear");
	cover property ($rose(irq));
	cover property (reg_rd && reg_addr == iopcn_pkg::OFS_PINS);
	cover property (reg_wr && reg_addr == iopcn_pkg::OFS_ODSEL);
endmodule : iopcn_chk

//--- sim/tb.sv
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin bad_count++; \
	$display("CHECK FAILED t=%0t got %h exp %h", $time, (g), (e)); end end
module tb;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic irq;
	logic cn_wake_req;
	logic [iopcn_pkg::ADDR_W-1:0] reg_addr = '0;
	logic [iopcn_pkg::DATA_W-1:0] reg_wdata = '0;
	logic [iopcn_pkg::DATA_W-1:0] reg_rdata;
	logic [iopcn_pkg::PORT_W-1:0] pin_in, pin_out, pin_oe_n;
	logic [iopcn_pkg::PORT_W-1:0] ext_val = '0;
	logic [iopcn_pkg::PORT_W-1:0] ext_drv = '0;
	logic [iopcn_pkg::AN_W-1:0] analog_channel_pins, adc_route_en;
	logic [iopcn_pkg::CN_W-1:0] change_notify_inputs, pullup_en;
	logic [iopcn_pkg::CN_W-1:0] cn_val = '0;
	logic [iopcn_pkg::CN_W-1:0] cn_drv = '0;
	int bad_count = 0;
	int check_count = 0;
	iopcn_top dut (.core_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.pin_in, .pin_out, .pin_oe_n, .analog_channel_pins, .adc_route_en,
		.change_notify_inputs, .pullup_en, .irq, .cn_wake_req);
	iopcn_pads pads (.core_clk, .pin_out, .pin_oe_n, .ext_val, .ext_drv, .cn_val, .cn_drv,
		.pullup_en, .pin_in, .change_notify_inputs);
	initial
	begin
		forever #10 core_clk = ~core_clk;
	end
	task automatic wr(input iopcn_pkg::iopcn_addr_t a, input iopcn_pkg::iopcn_word_t d);
		@(posedge core_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input iopcn_pkg::iopcn_addr_t a, input iopcn_pkg::iopcn_word_t e);
		@(posedge core_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		@(negedge core_clk);
		`CHK(reg_rdata, e);
	endtask : rd
	task automatic wait_edges(input int n);
		repeat (n) @(posedge core_clk);
		@(negedge core_clk);
	endtask : wait_edges
	task automatic end_of_test;
		$display("comparisons %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : end_of_test
	initial
	begin
		#400000;
		bad_count++;
		end_of_test();
	end
	initial
	begin
		repeat (4) @(posedge core_clk);
		rst <= 1'b0;
		@(negedge core_clk);
		`CHK(analog_channel_pins, 32'hffffffff);
		`CHK(pin_oe_n, 16'hffff);
		rd(iopcn_pkg::OFS_DIR, 16'hffff);
		rd(iopcn_pkg::OFS_ANA1_HI, 16'h0000);
		wr(iopcn_pkg::OFS_ANA1_LO, 16'hffff);
		wr(iopcn_pkg::OFS_ANA1_HI, 16'hffff);
		wr(iopcn_pkg::OFS_ANA2_LO, 16'hffff);
		wr(iopcn_pkg::OFS_ANA2_HI, 16'hffff);
		wait_edges(0);
		`CHK(analog_channel_pins, 32'h00000000);
		`CHK(adc_route_en, 32'h00000000);
		wr(iopcn_pkg::OFS_ANA2_LO, 16'hff0f);
		wr(iopcn_pkg::OFS_ANA1_HI, 16'hfffe);
		wait_edges(0);
		`CHK(analog_channel_pins, 32'h000100f0);
		`CHK(adc_route_en, 32'h000100f0);
		@(posedge core_clk);
		ext_drv <= 16'hffff;
		ext_val <= 16'ha5c3;
		wait_edges(3);
		rd(iopcn_pkg::OFS_PINS, 16'ha503);
		@(posedge core_clk);
		ext_drv <= 16'hff00;
		wr(iopcn_pkg::OFS_DIR, 16'hff00);
		wr(iopcn_pkg::OFS_LATCH, 16'h00a5);
		wait_edges(0);
		`CHK(pin_out, 16'h00a5);
		`CHK(pin_oe_n, 16'hff00);
		wr(iopcn_pkg::OFS_ODSEL, 16'h000f);
		wait_edges(0);
		`CHK(pin_out, 16'h00a0);
		`CHK(pin_oe_n, 16'hff05);
		wait_edges(3);
		rd(iopcn_pkg::OFS_PINS, 16'ha505);
		wr(iopcn_pkg::OFS_PULLUP_ENABLE_REG1, 16'hffff);
		wr(iopcn_pkg::OFS_PULLUP_ENABLE_REG2, 16'hffff);
		wait_edges(0);
		`CHK(pullup_en, 24'hffffff);
		rd(iopcn_pkg::OFS_PULLUP_ENABLE_REG2, 16'h00ff);
		wr(iopcn_pkg::OFS_IRQ_MASK, 16'h0001);
		rd(iopcn_pkg::OFS_IRQ_MASK, 16'h0001);
		wr(iopcn_pkg::OFS_CHANGE_IRQ_ENABLE_REG2, 16'h0080);
		wait_edges(4);
		rd(iopcn_pkg::OFS_IRQ_STAT, 16'h0000);
		@(posedge core_clk);
		cn_drv <= 24'h000001;
		wait_edges(8);
		`CHK(irq, 1'b0);
		@(posedge core_clk);
		cn_drv <= 24'h800001;
		#1;
		`CHK(cn_wake_req, 1'b1);
		wait_edges(6);
		`CHK(irq, 1'b1);
		`CHK(cn_wake_req, 1'b0);
		rd(iopcn_pkg::OFS_IRQ_STAT, 16'h0001);
		`CHK(irq, 1'b0);
		rd(iopcn_pkg::OFS_IRQ_STAT, 16'h0000);
		wr(iopcn_pkg::OFS_IRQ_MASK, 16'h0000);
		wr(iopcn_pkg::OFS_CHANGE_IRQ_ENABLE_REG1, 16'h0001);
		@(posedge core_clk);
		cn_val <= 24'h000001;
		wait_edges(8);
		`CHK(irq, 1'b0);
		rd(iopcn_pkg::OFS_IRQ_STAT, 16'h0001);
		wr(8'h1c, 16'hffff);
		rd(8'h1c, 16'h0000);
		rd(8'h03, 16'h0000);
		wr(iopcn_pkg::OFS_PULLUP_ENABLE_REG1, 16'hff00);
		wait_edges(0);
		`CHK(pullup_en, 24'hffff00);
		@(posedge core_clk);
		rst <= 1'b1;
		repeat (4) @(posedge core_clk);
		rst <= 1'b0;
		@(negedge core_clk);
		`CHK(analog_channel_pins, 32'hffffffff);
		`CHK(pullup_en, 24'h000000);
		end_of_test();
	end
endmodule : tb
bind iopcn_top iopcn_chk u_chk (.core_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
	.reg_rdata, .pin_out, .pin_oe_n, .analog_channel_pins, .adc_route_en, .pullup_en, .irq,
	.cn_wake_req);
